// ==== tb/adc_serial_output_port_tb.sv ====
// Self-checking bench for the converter serial output port
`timescale 1ns/1ps
`include "adc_serial_output_port_regs.svh"
`default_nettype none
module adc_serial_output_port_tb;
  logic                  clk, link_clk, reset_n, sclk_in, word_valid, word_ready, cs_n;
  logic                  mode_sel, sleep_n, cal_req, trim_type_a, trim_type_b, cal_start;
  logic                  serial_data_out, serial_data_oe, sclk_out, sclk_oe, data_ready_n;
  logic [1:0]            cal_type;
  logic [`WORD_BITS-1:0] word_data, rd;
  int                    errors, samples_checked, k;
  adc_serial_output_port uut (
    .clk(clk), .reset_n(reset_n), .sclk_in(sclk_in), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .cs_n(cs_n), .mode_sel(mode_sel),
    .sleep_n(sleep_n), .cal_req(cal_req), .trim_type_a(trim_type_a),
    .trim_type_b(trim_type_b), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .data_ready_n(data_ready_n), .cal_type(cal_type), .cal_start(cal_start)
  );
  host_model host (
    .link_clk(link_clk), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sclk_in(sclk_in)
  );
  // Master clock never stops; link clock unrelated in phase
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end
  // ====
  // Shared helpers
  function automatic logic [`WORD_BITS-1:0] pat(input int i);
    return 20'hA_5003 ^ {i[3:0], 12'h000, i[3:0]};
  endfunction
  task chk(input string n, input logic [`WORD_BITS-1:0] e, input logic [`WORD_BITS-1:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task push(input logic [`WORD_BITS-1:0] w);
    word_data <= w;
    word_valid <= 1'b1;
    @(posedge clk) word_valid <= 1'b0;
    @(posedge clk);
  endtask
  // One select per word; release only after the device lets go
  task frame(output logic [`WORD_BITS-1:0] w);
    for (k = 0; k < 40 && data_ready_n !== 1'b0; k++) @(negedge clk);
    @(posedge clk) cs_n <= 1'b0;
    // Six falling edges end 550 ns after select, inside the access limit
    for (k = 0; k < 6 && serial_data_oe !== 1'b1; k++) @(negedge clk);
    chk("data oe", 1'b1, serial_data_oe);
    if (mode_sel) host.self_read(w);
    else host.ext_read(w);
    for (k = 0; k < 16 && serial_data_oe !== 1'b0; k++) @(negedge clk);
    @(posedge clk) cs_n <= 1'b1;
  endtask
  // ====
  // Scenarios
  task t_ignore;
    @(posedge clk) cs_n <= 1'b0;
    repeat (15) @(negedge clk);
    chk("oe while idle", 1'b0, serial_data_oe);
    @(posedge clk) cs_n <= 1'b1;
    $display("ignore test done");
  endtask
  task t_cal;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk) {trim_type_b, trim_type_a} <= c[1:0];
      @(posedge clk) cal_req <= 1'b1;
      for (k = 0; k < 8 && cal_start !== 1'b1; k++) @(negedge clk);
      chk("cal_start", 1'b1, cal_start);
      chk("cal_type", c[1:0], cal_type);
      @(posedge clk) cal_req <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("calibration test done");
  endtask
  // Fill while asleep; the output register holds one word past the depth
  task t_fill;
    for (int i = 0; i <= `FIFO_DEPTH; i++) push(pat(i));
    @(negedge clk);
    chk("word_ready full", 1'b0, word_ready);
    @(posedge clk) sleep_n <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i <= `FIFO_DEPTH; i++) begin
      frame(rd);
      chk("ext word", pat(i), rd);
    end
    $display("fill and drain test done");
  endtask
  task t_self;
    @(posedge clk) mode_sel <= 1'b1;
    push(20'h3_C5A9);
    frame(rd);
    chk("self word", 20'h3_C5A9, rd);
    $display("self clock test done");
  endtask
  task t_abort;
    push(20'hF_0F0F);
    for (k = 0; k < 40 && data_ready_n !== 1'b0; k++) @(negedge clk);
    @(posedge clk) cs_n <= 1'b0;
    repeat (3) @(posedge sclk_out);
    @(posedge clk) cs_n <= 1'b1;
    for (k = 0; k < 14 && serial_data_oe !== 1'b0; k++) @(negedge clk);
    chk("released", 1'b0, serial_data_oe | sclk_oe);
    // External clock mode: host clock stays still, select alone must free the pins
    @(posedge clk) mode_sel <= 1'b0;
    push(20'h0_F0F0);
    for (k = 0; k < 40 && data_ready_n !== 1'b0; k++) @(negedge clk);
    @(posedge clk) cs_n <= 1'b0;
    for (k = 0; k < 6 && serial_data_oe !== 1'b1; k++) @(negedge clk);
    chk("ext data oe", 1'b1, serial_data_oe);
    @(posedge clk) cs_n <= 1'b1;
    for (k = 0; k < 6 && serial_data_oe !== 1'b0; k++) @(negedge clk);
    chk("ext released", 1'b0, serial_data_oe | sclk_oe);
    $display("abort test done");
  endtask
  // Main sequence
  initial begin
    {reset_n, word_valid, cal_req, trim_type_a, trim_type_b, mode_sel, sleep_n} = '0;
    cs_n = 1'b1;
    word_data = '0;
    errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reset ready_n", 1'b1, data_ready_n);
    chk("reset oe", 1'b0, serial_data_oe | sclk_oe);
    t_ignore;
    t_cal;
    t_fill;
    t_self;
    t_abort;
    end_sim;
  end
  // Watchdog: the whole run needs well under 1 ms
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host serial port model at the far side of the output port
`timescale 1ns/1ps
`include "adc_serial_output_port_regs.svh"
`default_nettype none
module host_model (
  input  wire logic link_clk,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe,
  input  wire logic sclk_out,
  input  wire logic sclk_oe,
  output var logic  sclk_in
);
  logic last_q;
  logic sd;
  logic sclk_w;
  // A released line shows the inverse of its last value, never a held copy
  always @(posedge link_clk) if (serial_data_oe) last_q <= serial_data_out;
  assign sd     = serial_data_oe ? serial_data_out : ~last_q;
  assign sclk_w = sclk_oe ? sclk_out : sclk_in;
  initial sclk_in = 1'b0;
  // ====
  // Host clock: 1024 ns period, stands low between frames
  task ext_read(output logic [`WORD_BITS-1:0] w);
    repeat (`WORD_BITS) begin
      repeat (8) @(posedge link_clk);
      w = {w[`WORD_BITS-2:0], sd};
      sclk_in = 1'b1;
      repeat (8) @(posedge link_clk);
      sclk_in = 1'b0;
    end
  endtask
  // Device clock: take each bit on the rising edge
  task self_read(output logic [`WORD_BITS-1:0] w);
    repeat (`WORD_BITS) begin
      @(posedge sclk_w);
      w = {w[`WORD_BITS-2:0], sd};
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/port_chk.sv ====
// Checker for the converter serial output port
`timescale 1ns/1ps
`default_nettype none
module port_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sclk_in,
  input wire logic       cs_n,
  input wire logic       mode_sel,
  input wire logic       cal_req,
  input wire logic       trim_type_a,
  input wire logic       trim_type_b,
  input wire logic       serial_data_out,
  input wire logic       serial_data_oe,
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic       data_ready_n,
  input wire logic [1:0] cal_type,
  input wire logic       cal_start
);
  // ====
  // Frame control, one clock domain only
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rel;
    serial_data_oe && $rose(cs_n) |-> ##[1:12] (!serial_data_oe && !sclk_oe);
  endproperty
  a_rel: assert property (p_rel) else $error("outputs not released");
  property p_ign; data_ready_n && $fell(cs_n) |=> !serial_data_oe [*8]; endproperty
  a_ign: assert property (p_ign) else $error("select not ignored");
  property p_gap; $rose(data_ready_n) |=> data_ready_n [*3]; endproperty
  a_gap: assert property (p_gap) else $error("ready gap short");
  property p_acc; !data_ready_n && $fell(cs_n) |-> ##[1:5] serial_data_oe; endproperty
  a_acc: assert property (p_acc) else $error("data access late");
  // Shifting only while the host clock has been low for a while
  property p_sft;
    !mode_sel && serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out)
      |-> !sclk_in && !$past(sclk_in, 2);
  endproperty
  a_sft: assert property (p_sft) else $error("shift not after falling edge");
  property p_ext; !mode_sel |-> !sclk_oe; endproperty
  a_ext: assert property (p_ext) else $error("clock driven in ext mode");
  property p_qtr;
    sclk_oe && $rose(sclk_out) |=> (!sclk_out || !sclk_oe) [*3] ##1 (sclk_out || !sclk_oe);
  endproperty
  a_qtr: assert property (p_qtr) else $error("serial clock shape wrong");
  property p_cal;
    $rose(cal_req) |-> ##[1:5] (cal_start && cal_type == {trim_type_b, trim_type_a});
  endproperty
  a_cal: assert property (p_cal) else $error("trim type not captured");
endmodule
bind adc_serial_output_port port_chk u_chk (
  .clk(clk), .reset_n(reset_n), .sclk_in(sclk_in), .cs_n(cs_n), .mode_sel(mode_sel),
  .cal_req(cal_req), .trim_type_a(trim_type_a), .trim_type_b(trim_type_b),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .data_ready_n(data_ready_n),
  .cal_type(cal_type), .cal_start(cal_start)
);
`default_nettype wire

// ==== verilog/adc_serial_output_port.sv ====
// Serial output port that shifts 20-bit conversion words to a host
// Operation
// - Chip select released mid-word: self clock mode finishes current bit, external clock mode stops at once; then float data and clock.
// - Chip select falling during the five-cycle ready-high gap is ignored.
// - Asynchronous chip select acts within four master cycles plus 160 ns.
// - External clock mode: data advances on each falling serial clock edge.
// - Mode select low: external serial clock input, most significant bit first.
// - Mode select high: device drives serial clock at quarter rate, 25% high.
// - Calibration type pins are captured when calibration request rises.
`timescale 1ns/1ps
`include "adc_serial_output_port_regs.svh"
`default_nettype none
module adc_serial_output_port
  import adc_serial_output_port_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sclk_in,
  input  wire logic [`WORD_BITS-1:0] word_data,
  input  wire logic                  word_valid,
  output logic                       word_ready,
  input  wire logic                  cs_n,
  input  wire logic                  mode_sel,
  input  wire logic                  sleep_n,
  input  wire logic                  cal_req,
  input  wire logic                  trim_type_a,
  input  wire logic                  trim_type_b,
  output logic                       serial_data_out,
  output logic                       serial_data_oe,
  output logic                       sclk_out,
  output logic                       sclk_oe,
  output logic                       data_ready_n,
  output logic [1:0]                 cal_type,
  output logic                       cal_start
);
  // =====================================================================
  // Input synchronisers
  // =====================================================================
  logic [1:0] cs_s_q, mode_s_q, sleep_s_q, cal_s_q, ta_s_q, tb_s_q;
  logic       cs_sync;
  logic       cal_prev_q;

  // Two stages on every pin; only the second stage is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s_q    <= 2'b11;
      mode_s_q  <= 2'b00;
      sleep_s_q <= 2'b00;
      cal_s_q   <= 2'b00;
      ta_s_q    <= 2'b00;
      tb_s_q    <= 2'b00;
    end else begin
      cs_s_q    <= {cs_s_q[0], cs_n};
      mode_s_q  <= {mode_s_q[0], mode_sel};
      sleep_s_q <= {sleep_s_q[0], sleep_n};
      cal_s_q   <= {cal_s_q[0], cal_req};
      ta_s_q    <= {ta_s_q[0], trim_type_a};
      tb_s_q    <= {tb_s_q[0], trim_type_b};
    end
  end

  // =====================================================================
  // Calibration type capture
  // =====================================================================
  logic [1:0] cal_type_d;
  logic       cal_start_d, cal_rise;
  assign cal_rise = cal_s_q[1] && !cal_prev_q;
  always_comb begin
    cal_type_d  = cal_rise ? {tb_s_q[1], ta_s_q[1]} : cal_type;
    cal_start_d = cal_rise;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_prev_q <= 1'b0;
      cal_type   <= 2'b00;
      cal_start  <= 1'b0;
    end else begin
      cal_prev_q <= cal_s_q[1];
      cal_type   <= cal_type_d;
      cal_start  <= cal_start_d;
    end
  end

  // =====================================================================
  // Word buffer
  // =====================================================================
  logic                  fifo_valid, fifo_take;
  logic [`WORD_BITS-1:0] fifo_data;
  word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  // =====================================================================
  // Frame control on the master clock
  // =====================================================================
  port_state_t           st_q, st_d;
  logic [`WORD_BITS-1:0] sh_q, sh_d;
  logic [`BIT_CNT_W-1:0] bit_q, bit_d;
  logic [2:0]            wait_q, wait_d;
  logic [1:0]            div_q, div_d;
  logic [2:0]            gap_q, gap_d;
  logic                  rdy_n_d, sdo_d, sdo_oe_d, sck_d, sck_oe_d;
  logic                  cs_prev_q, cs_fall, ext_fall, ext_mode;
  logic [1:0]            efall_q;
  logic                  efall_prev_q;
  logic                  ext_edge_tog_q;

  assign ext_mode = !mode_s_q[1];
  // No extra stages on select: the access limit leaves room for two only
  assign cs_sync  = cs_s_q[1];
  assign cs_fall  = !cs_sync && cs_prev_q;
  assign ext_fall = efall_q[1] != efall_prev_q;
  assign fifo_take = (st_q == ST_IDLE) && fifo_valid && data_ready_n && (gap_q == 3'd0)
                     && sleep_s_q[1];

  always_comb begin
    st_d     = st_q;
    sh_d     = sh_q;
    bit_d    = bit_q;
    wait_d   = wait_q;
    div_d    = div_q;
    gap_d    = (gap_q != 3'd0) ? gap_q - 3'd1 : gap_q;
    rdy_n_d  = data_ready_n;
    sdo_d    = serial_data_out;
    sdo_oe_d = serial_data_oe;
    sck_d    = sclk_out;
    sck_oe_d = sclk_oe;
    case (st_q)
      ST_IDLE: begin
        sdo_oe_d = 1'b0;
        sck_oe_d = 1'b0;
        if (fifo_take) begin
          sh_d    = fifo_data;
          rdy_n_d = 1'b0;
        end else if (!data_ready_n && cs_fall) begin
          st_d   = ST_WAIT;
          wait_d = 3'(`CS_WAIT_CYC - 1);
        end
      end
      ST_WAIT: begin
        if (cs_sync) begin
          st_d = ST_IDLE;
        end else if (wait_q == 3'd0) begin
          st_d     = ST_SHIFT;
          bit_d    = 5'(`WORD_BITS - 1);
          sdo_d    = sh_q[`WORD_BITS-1];
          sdo_oe_d = 1'b1;
          sck_oe_d = !ext_mode;
          sck_d    = 1'b0;
          div_d    = 2'd0;
        end else begin
          wait_d = wait_q - 3'd1;
        end
      end
      ST_SHIFT: begin
        if (ext_mode) begin
          // A stopped host clock must not hold the pins once select is gone
          if (cs_sync) begin
            st_d = ST_DONE;
          end else if (ext_fall) begin
            if (bit_q == 5'd0) begin
              st_d = ST_DONE;
            end else begin
              sh_d  = {sh_q[`WORD_BITS-2:0], 1'b0};
              sdo_d = sh_q[`WORD_BITS-2];
              bit_d = bit_q - 5'd1;
            end
          end
        end else begin
          div_d = div_q + 2'd1;
          sck_d = (div_q == 2'd2);
          if (div_q == 2'd3) begin
            if (bit_q == 5'd0 || cs_sync) begin
              st_d = ST_DONE;
            end else begin
              sh_d  = {sh_q[`WORD_BITS-2:0], 1'b0};
              sdo_d = sh_q[`WORD_BITS-2];
              bit_d = bit_q - 5'd1;
            end
          end
        end
      end
      ST_DONE: begin
        // Float outputs and open the ready-high gap
        sdo_oe_d = 1'b0;
        sck_oe_d = 1'b0;
        sck_d    = 1'b0;
        rdy_n_d  = 1'b1;
        gap_d    = 3'(`READY_HIGH_CYC);
        st_d     = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Frame registers; select edges read only the second synchroniser stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_prev_q       <= 1'b1;
      efall_q         <= 2'b00;
      efall_prev_q    <= 1'b0;
      st_q            <= ST_IDLE;
      sh_q            <= '0;
      bit_q           <= '0;
      wait_q          <= '0;
      div_q           <= '0;
      gap_q           <= '0;
      data_ready_n    <= 1'b1;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
      sclk_out        <= 1'b0;
      sclk_oe         <= 1'b0;
    end else begin
      cs_prev_q       <= cs_sync;
      efall_q         <= {efall_q[0], ext_edge_tog_q};
      efall_prev_q    <= efall_q[1];
      st_q            <= st_d;
      sh_q            <= sh_d;
      bit_q           <= bit_d;
      wait_q          <= wait_d;
      div_q           <= div_d;
      gap_q           <= gap_d;
      data_ready_n    <= rdy_n_d;
      serial_data_out <= sdo_d;
      serial_data_oe  <= sdo_oe_d;
      sclk_out        <= sck_d;
      sclk_oe         <= sck_oe_d;
    end
  end

  // =====================================================================
  // Link clock domain: toggle per falling host clock edge
  // =====================================================================
  // Host clock may stop between frames; the toggle simply holds
  always_ff @(negedge sclk_in or negedge reset_n) begin
    if (!reset_n) begin
      ext_edge_tog_q <= 1'b0;
    end else begin
      ext_edge_tog_q <= !ext_edge_tog_q;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/adc_serial_output_port_pkg.sv ====
// Types for the converter serial output port
package adc_serial_output_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE  = 2'b11
  } port_state_t;
endpackage

// ==== verilog/adc_serial_output_port_regs.svh ====
// Constants for the converter serial output port
`ifndef ADC_SERIAL_OUTPUT_PORT_REGS_SVH
`define ADC_SERIAL_OUTPUT_PORT_REGS_SVH
`define WORD_BITS        20
`define BIT_CNT_W        5
`define CLK_PERIOD_NS    100
`define CS_DELAY_NS      160
`define CS_DELAY_CYC     ((`CS_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_SETTLE_CYC    (4 + `CS_DELAY_CYC)
// One settle cycle after the synchroniser keeps select-to-data inside the access limit
`define CS_WAIT_CYC      1
`define READY_HIGH_CYC   4
`define SCLK_DIV         4
`define FIFO_DEPTH       8
`define FIFO_AW          3
`endif

// ==== verilog/word_fifo.sv ====
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic             ov_q, ov_d;
  logic             full, empty, push, pop;
  logic             rdy_q, rdy_d;

  // Ready leaves a flop, so full is judged one cycle ahead on the next pointers
  assign full     = !rdy_q;
  assign empty    = (wr_q == rd_q);
  assign in_ready = rdy_q;
  assign push     = in_valid && !full;
  // Output register refills whenever it is free or being taken
  assign pop      = !empty && (!ov_q || out_ready);
  assign out_valid = ov_q;
  assign out_data  = out_q;

  // Next pointer and output register values
  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    out_d = pop ? mem_q[rd_q[AW-1:0]] : out_q;
    ov_d  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    rdy_d = !((wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]));
  end

  // Storage carries no reset; pointers guard its contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      out_q <= '0;
      ov_q  <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      out_q <= out_d;
      ov_q  <= ov_d;
      rdy_q <= rdy_d;
    end
  end
endmodule
`default_nettype wire
